// >>> scif_pkg.sv
// Purpose: Constants for the smart card interrupt flag block
// Assumes: 8-bit special-function-register bus, 20 MHz clock
// Notes:   Offsets are byte addresses on the SFR bus
package scif_pkg;
	localparam logic [15:0] ADDR_SELECT    = 16'hfe00;
	localparam logic [15:0] ADDR_STATUS    = 16'hfe01;
	localparam logic [15:0] ADDR_ENABLE    = 16'hfe02;
	localparam logic [15:0] ADDR_SUPPLY    = 16'hfe03;
	localparam logic [7:0]  RESET_STATUS   = 8'h00;
	localparam logic [7:0]  RESET_ENABLE   = 8'h00;
	localparam logic [7:0]  RESET_SUPPLY   = 8'h00;
	localparam logic [7:0]  RESET_SELECT   = 8'h00;
	localparam int BIT_WAIT    = 7;
	localparam int BIT_CARD    = 6;
	localparam int BIT_SUPPLY  = 5;
	localparam int BIT_RXDATA  = 4;
	localparam int BIT_TXFIFO  = 3;
	localparam int BIT_SENT    = 2;
	localparam int BIT_TX_ERROR_FLAG   = 1;
	localparam int BIT_RX_ERROR_FLAG   = 0;
	localparam int SUP_SEL_HI  = 7;
	localparam int SUP_SEL_LO  = 6;
	localparam int SUP_FAULT   = 5;
	localparam int SUP_POWER_DOWN_BIT   = 0;
	localparam logic [7:0] SUPPLY_WR_MASK = 8'hf1;
	localparam int SEL_BYPASS  = 1;
	localparam int SEL_IF_HI   = 3;
	localparam int SEL_IF_LO   = 2;
endpackage

// >>> scif_top.sv
// Purpose: Smart card interrupt status, enable and supply control entry
// Assumes: SFR bus with one-cycle read and write strobes, all inputs synchronous
// Notes:   Register reads and writes take effect on the strobe edge
// Function
// RL1: Bit 7 sets on answer-to-reset or card wait timeout.
// RL2: In sync mode bit 7 sets when receive-length counter reaches maximum.
// RL3: In clock start/stop mode bit 7 is the receive-length terminal interrupt.
// RL4: Status read clears wait, card event, supply timer and byte sent flags.
// RL5: Bit 6 sets on card insertion, removal or interface fault.
// RL6: Card event detection works with logic clock gated or power down set.
// RL7: Bit 5 sets when the supply stable timer expires.
// RL8: Bit 4 follows receive FIFO non-empty.
// RL9: In bypass mode bit 4 sets on falling edges of the I/O line.
// RL10: Firmware masks bypass receive interrupt until the byte is fully taken.
// RL11: Bit 3 sets on FIFO empty or full rising, clears on tx control read.
// RL12: Bit 2 sets per sent byte, except T=0 byte ending in detected break.
// RL13: Bit 1 sets on break or underrun, clears on tx control read.
// RL14: Bit 0 sets on overrun or parity error, clears on rx control read.
// RL15: Enable bit gates its cause onto the interrupt; flags set regardless.
// RL16: Enable bits match status bits; bit 7 gates receive-length interrupt.
// RL17: Firmware writes both supply level select bits in one write.
// RL18: With fault option set, a core supply fault forces emergency deactivation.
// RL19: Flags reflect the card interface currently selected onto the UART.
// RL20: Interrupt request is OR of status flags ANDed with enables.
`timescale 1ns/1ps
`default_nettype none

module scif_top (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// SFR bus
	input  wire logic [15:0] sfr_addr,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_rd,
	input  wire logic [7:0]  sfr_wdata,
	output logic      [7:0]  sfr_rdata,
	// Cause inputs: modes, FIFO flags, card detect, I/O and supply fault are levels; the rest are one-cycle pulses
	input  wire logic        sync_mode,
	input  wire logic        atr_timeout,
	input  wire logic        wait_timeout,
	input  wire logic        rlen_at_max,
	input  wire logic        card_detect_input,
	input  wire logic        supply_stable_timer,
	input  wire logic        rx_fifo_not_empty,
	input  wire logic        io_line,
	input  wire logic        tx_fifo_empty,
	input  wire logic        tx_fifo_full,
	input  wire logic        byte_sent,
	input  wire logic        t0_mode,
	input  wire logic        break_enable,
	input  wire logic        break_detected,
	input  wire logic        tx_underrun,
	input  wire logic        rx_overrun,
	input  wire logic        rx_parity_error,
	input  wire logic        tx_control_rd,
	input  wire logic        rx_control_rd,
	input  wire logic        core_supply_fault,
	// Outputs
	output logic             card_irq,
	output logic             emergency_deact,
	output logic [1:0]       supply_level_select,
	output logic             uart_bypass,
	output logic [1:0]       uart_interface_sel
);
	// ****************************************
	// Registers and edge history
	// ****************************************
	logic [7:0] card_irq_status;
	logic [7:0] card_irq_enable;
	logic [7:0] card_supply_control;
	logic [7:0] card_select;
	logic       card_det_q;
	logic       io_q;
	logic       tx_empty_q;
	logic       tx_full_q;

	// ****************************************
	// Decode and cause terms
	// ****************************************
	wire logic hit_status = sfr_addr == scif_pkg::ADDR_STATUS;
	wire logic hit_enable = sfr_addr == scif_pkg::ADDR_ENABLE;
	wire logic hit_supply = sfr_addr == scif_pkg::ADDR_SUPPLY;
	wire logic hit_select = sfr_addr == scif_pkg::ADDR_SELECT;
	wire logic rd_status  = sfr_rd && hit_status;
	wire logic bypass     = card_select[scif_pkg::SEL_BYPASS];
	// Wait timeout in async mode, receive-length max in sync modes
	wire logic set_wait   = sync_mode ? rlen_at_max : (atr_timeout | wait_timeout); // RL1 RL2 RL3
	// Any change of the detect level counts: insertion, removal or fault
	wire logic set_card   = card_detect_input ^ card_det_q; // RL5
	wire logic set_supply = supply_stable_timer; // RL7
	wire logic io_fall    = io_q & ~io_line;
	wire logic set_txfifo = (tx_fifo_empty & ~tx_empty_q) | (tx_fifo_full & ~tx_full_q); // RL11
	wire logic set_sent   = byte_sent & ~(t0_mode & break_enable & break_detected); // RL12
	wire logic set_tx_error_flag  = break_detected | tx_underrun; // RL13
	wire logic set_rx_error_flag  = rx_overrun | rx_parity_error; // RL14
	// Set wins over a same-cycle clear
	wire logic [7:0] next_status = {
		set_wait   | (card_irq_status[scif_pkg::BIT_WAIT]   & ~rd_status), // RL4
		set_card   | (card_irq_status[scif_pkg::BIT_CARD]   & ~rd_status), // RL4
		set_supply | (card_irq_status[scif_pkg::BIT_SUPPLY] & ~rd_status), // RL4
		// Bypass: sticky edge flag, cleared once no data sits in the FIFO
		bypass ? (io_fall | (card_irq_status[scif_pkg::BIT_RXDATA] & rx_fifo_not_empty))
		       : rx_fifo_not_empty, // RL8 RL9
		set_txfifo | (card_irq_status[scif_pkg::BIT_TXFIFO] & ~tx_control_rd), // RL11
		set_sent   | (card_irq_status[scif_pkg::BIT_SENT]   & ~rd_status), // RL4 RL12
		set_tx_error_flag  | (card_irq_status[scif_pkg::BIT_TX_ERROR_FLAG]  & ~tx_control_rd), // RL13
		set_rx_error_flag  | (card_irq_status[scif_pkg::BIT_RX_ERROR_FLAG]  & ~rx_control_rd)  // RL14
	};
	wire logic next_irq = |(next_status & card_irq_enable); // RL15 RL16 RL20
	wire logic [7:0] read_mux =
		hit_status ? card_irq_status :
		hit_enable ? card_irq_enable :
		hit_supply ? card_supply_control :
		hit_select ? card_select : 8'h00;

	// ****************************************
	// Flags
	// ****************************************
	// The card event path samples the detect level on this same clock; in silicon
	// this flop pair sits in the always-on domain so gating and power down spare it.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			card_det_q <= 1'b0;
			io_q       <= 1'b1;
			tx_empty_q <= 1'b0;
			tx_full_q  <= 1'b0;
		end else begin
			card_det_q <= card_detect_input; // RL6
			io_q       <= io_line;
			tx_empty_q <= tx_fifo_empty;
			tx_full_q  <= tx_fifo_full;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			card_irq_status <= scif_pkg::RESET_STATUS;
			card_irq        <= 1'b0;
		end else begin
			card_irq_status <= next_status; // RL19
			card_irq        <= next_irq; // RL20
		end
	end

	// ****************************************
	// Register writes and read data
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			card_irq_enable     <= scif_pkg::RESET_ENABLE;
			card_supply_control <= scif_pkg::RESET_SUPPLY;
			card_select         <= scif_pkg::RESET_SELECT;
		end else if (sfr_wr) begin
			if (hit_enable)
				card_irq_enable <= sfr_wdata; // RL15
			// Both select bits land in one write, so no transient level is seen
			if (hit_supply)
				card_supply_control <= sfr_wdata & scif_pkg::SUPPLY_WR_MASK; // RL17
			if (hit_select)
				card_select <= sfr_wdata; // RL19
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sfr_rdata           <= 8'h00;
			emergency_deact     <= 1'b0;
			supply_level_select <= 2'h0;
			uart_bypass         <= 1'b0;
			uart_interface_sel  <= 2'h0;
		end else begin
			sfr_rdata           <= sfr_rd ? read_mux : 8'h00;
			emergency_deact     <= core_supply_fault & card_supply_control[scif_pkg::SUP_FAULT]; // RL18
			supply_level_select <= card_supply_control[scif_pkg::SUP_SEL_HI:scif_pkg::SUP_SEL_LO];
			uart_bypass         <= bypass;
			uart_interface_sel  <= card_select[scif_pkg::SEL_IF_HI:scif_pkg::SEL_IF_LO];
		end
	end
endmodule // scif_top

`default_nettype wire

// >>> scif_props.sv
// Purpose: Port assertions for scif_top
// Assumes: Read data is valid the cycle after the strobe
// Notes:   Bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module scif_props (
	// Clock, reset and bus
	input wire logic        clk, rst, sfr_rd, sfr_wr,
	input wire logic [15:0] sfr_addr,
	input wire logic [7:0]  sfr_wdata, sfr_rdata,
	// Causes and outputs
	input wire logic        atr_timeout, wait_timeout, rlen_at_max, supply_stable_timer, byte_sent,
	input wire logic        rx_fifo_not_empty, uart_bypass, tx_control_rd, break_detected, tx_underrun,
	input wire logic        rx_control_rd, rx_overrun, rx_parity_error, core_supply_fault, emergency_deact,
	input wire logic [1:0]  supply_level_select
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire rd_st  = sfr_rd && sfr_addr == scif_pkg::ADDR_STATUS;
	wire quiet  = !(atr_timeout || wait_timeout || rlen_at_max || supply_stable_timer || byte_sent);
	wire tx_bad = break_detected || tx_underrun;
	wire rx_bad = rx_overrun || rx_parity_error;
	// ********
	// Status flags, read data one cycle late
	// ********
	property p_clr; rd_st && quiet ##1 quiet ##1 rd_st |=> (sfr_rdata & 8'ha4) == 8'h00; endproperty
	a_clr: assert property (p_clr) else $error("flag kept after status read");
	property p_rxd_set; rd_st && rx_fifo_not_empty && $past(rx_fifo_not_empty) |=> sfr_rdata[4]; endproperty
	a_rxd_set: assert property (p_rxd_set) else $error("rx data flag low with data");
	property p_rxd_clr; rd_st && !rx_fifo_not_empty && !$past(rx_fifo_not_empty) && !uart_bypass |=> !sfr_rdata[4]; endproperty
	a_rxd_clr: assert property (p_rxd_clr) else $error("rx data flag high when empty");
	property p_txe_clr; tx_control_rd && !tx_bad ##1 !tx_bad ##1 rd_st |=> !sfr_rdata[1]; endproperty
	a_txe_clr: assert property (p_txe_clr) else $error("tx error kept");
	property p_rxe_clr; rx_control_rd && !rx_bad ##1 !rx_bad ##1 rd_st |=> !sfr_rdata[0]; endproperty
	a_rxe_clr: assert property (p_rxe_clr) else $error("rx error kept");
	property p_rxe_set; rx_overrun && !rx_control_rd ##1 !rx_control_rd ##1 rd_st |=> sfr_rdata[0]; endproperty
	a_rxe_set: assert property (p_rxe_set) else $error("rx error not set");
	// ********
	// Supply control
	// ********
	// Level select is registered from the control register, so it lags the write by two edges
	property p_lvl; sfr_wr && sfr_addr == scif_pkg::ADDR_SUPPLY |-> ##2 {supply_level_select, 6'h00} == ($past(sfr_wdata, 2) & 8'hc0); endproperty
	a_lvl: assert property (p_lvl) else $error("level select not both bits");
	property p_flt; !core_supply_fault |=> !emergency_deact; endproperty
	a_flt: assert property (p_flt) else $error("deactivation without fault");
endmodule // scif_props
`default_nettype wire

// >>> scif_card_model.sv
// Purpose: Card side of the interface
// Assumes: I/O line has a pull-up, so idle reads high
// Notes:   Behavioural, no protocol timing
`timescale 1ns/1ps
`default_nettype none
module scif_card_model (
	input wire logic clk, present, start,
	output logic     card_detect_input, io_line
);
	// Detect follows the slot; a start bit pulls the line low
	assign card_detect_input = present;
	assign io_line           = !start;
endmodule // scif_card_model
`default_nettype wire

// >>> tb_scif_top.sv
// Purpose: Self-checking bench for scif_top
// Assumes: 20 MHz clock, reset held five cycles
// Notes:   Causes packed in one vector so one task pulses any mix
`timescale 1ns/1ps
`default_nettype none
module tb_scif_top;
	logic        clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, present = 1'b0, start = 1'b0;
	logic [15:0] sfr_addr = 16'h0000;
	logic [7:0]  sfr_wdata = 8'h00, sfr_rdata;
	logic [17:0] in = 18'h00000;
	logic [1:0]  supply_level_select, uart_interface_sel;
	logic        card_irq, emergency_deact, uart_bypass;
	wire         card_detect_input, io_line, core_supply_fault, tx_fifo_full, tx_fifo_empty, rx_fifo_not_empty;
	wire         break_enable, t0_mode, sync_mode, rx_control_rd, tx_control_rd, rlen_at_max, atr_timeout;
	wire         wait_timeout, supply_stable_timer, byte_sent, tx_underrun, break_detected, rx_parity_error, rx_overrun;
	int          error_cnt = 0, num_checks = 0, cycles = 0;
	assign {core_supply_fault, tx_fifo_full, tx_fifo_empty, rx_fifo_not_empty, break_enable, t0_mode, sync_mode,
		rx_control_rd, tx_control_rd, rlen_at_max, atr_timeout, wait_timeout, supply_stable_timer, byte_sent,
		tx_underrun, break_detected, rx_parity_error, rx_overrun} = in;
	scif_top dut (.*);
	scif_card_model card (.*);
	always #25 clk = ~clk;
	// ********
	// Tasks
	// ********
	task automatic ck(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		{sfr_wr, sfr_rd, sfr_addr, sfr_wdata} <= {w, !w, a, d};
		@(posedge clk);
		{sfr_wr, sfr_rd} <= 2'h0;
		#1;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		ck(sfr_rdata, e);
	endtask
	task automatic pulse(input logic [17:0] m);
		@(posedge clk) in <= in | m;
		@(posedge clk) in <= in & ~m;
	endtask
	task automatic final_report;
		if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// ********
	// Scenarios
	// ********
	task automatic t_flags;
		rd(scif_pkg::ADDR_ENABLE, 8'h00);
		pulse(18'h00080);
		@(posedge clk) present <= 1'b1;
		pulse(18'h00030);
		rd(scif_pkg::ADDR_STATUS, 8'he4);
		rd(scif_pkg::ADDR_STATUS, 8'h00);
		@(posedge clk) in[11] <= 1'b1;
		pulse(18'h00040);
		pulse(18'h00100);
		rd(scif_pkg::ADDR_STATUS, 8'h80);
		@(posedge clk) in[13:11] <= 3'h6;
		pulse(18'h00014);
		@(posedge clk) in[15] <= 1'b1;
		rd(scif_pkg::ADDR_STATUS, 8'h0a);
		pulse(18'h00200);
		rd(scif_pkg::ADDR_STATUS, 8'h00);
		@(posedge clk) in[14] <= 1'b1;
		rd(scif_pkg::ADDR_STATUS, 8'h10);
		rd(scif_pkg::ADDR_STATUS, 8'h10);
		@(posedge clk) in[14] <= 1'b0;
		rd(scif_pkg::ADDR_STATUS, 8'h00);
	endtask
	task automatic t_irq;
		pulse(18'h00001);
		rd(scif_pkg::ADDR_STATUS, 8'h01);
		ck({7'h00, card_irq}, 8'h00);
		bus(1'b1, scif_pkg::ADDR_ENABLE, 8'h01);
		cyc(1);
		ck({7'h00, card_irq}, 8'h01);
		pulse(18'h00400);
		rd(scif_pkg::ADDR_STATUS, 8'h00);
		ck({7'h00, card_irq}, 8'h00);
	endtask
	task automatic t_supply;
		bus(1'b1, scif_pkg::ADDR_SUPPLY, 8'hff);
		rd(scif_pkg::ADDR_SUPPLY, 8'hf1);
		ck({6'h00, supply_level_select}, 8'h03);
		@(posedge clk) in[17] <= 1'b1;
		cyc(2);
		ck({7'h00, emergency_deact}, 8'h01);
		rd(16'hfe07, 8'h00);
		bus(1'b1, scif_pkg::ADDR_SELECT, 8'h0e);
		cyc(1);
		ck({5'h00, uart_interface_sel, uart_bypass}, 8'h07);
		// Receive data interrupt stays masked in bypass while the byte comes in
		@(posedge clk) start <= 1'b1;
		rd(scif_pkg::ADDR_STATUS, 8'h10);
		ck({7'h00, card_irq}, 8'h00);
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			error_cnt++;
			final_report();
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_flags();
		t_irq();
		t_supply();
		final_report();
	end
endmodule // tb_scif_top
bind scif_top scif_props props (.*);
`default_nettype wire
